// ---- logic/nvs_pkg.sv ----
// Shared constants and types for both ends of the serial memory link.
// How it works
// [R1] Device holds 8,192 bytes of storage.
// [R2] Respond only when address code matches straps.
// [R3] Unconnected strap pins read as low.
// [R4] Device data output is open-drain only.
// [R5] Sample on clock rise, drive on fall.
// [R6] Write-lock high blocks all memory writes.
// [R7] Reads work whatever the write-lock level.
// [R8] Undriven write-lock reads low, writes allowed.
// [R9] Master alone starts transfers and clocks.
// [R10] Data changes only while clock is low.
// [R11] Start is data falling while clock high.
// [R12] Stop is data rising while clock high.
// [R13] Stop after write gives immediate standby.
// [R14] Receiver pulls data low on ninth clock.
// [R15] Transmitter releases data on ninth clock.
// [R16] Stop before acknowledge ends the read.
// [R17] No acknowledge and no stop: stay released.
// [R18] Master clock never above 400 kHz.
// [R19] Mismatched address: released until next start.
// [R20] Eighth address bit selects read or write.
// [R21] Two address bytes, high byte first.
// [R22] Address increments per byte, wraps to zero.
// [R23] Addressless read returns last address plus one.
package nvs_pkg;

   localparam int          MEM_WORDS     = 8192;
   localparam int          ADDR_W        = 13;
   localparam int          BYTE_BITS     = 8;
   localparam logic [3:0]  ACK_BIT       = 4'h8;
   localparam logic [3:0]  LAST_BIT      = 4'h7;
   localparam logic [3:0]  TYPE_CODE     = 4'h5;   // Arbitrary value.
   localparam int          TYPE_MSB      = 7;
   localparam int          TYPE_LSB      = 4;
   localparam int          STRAP_MSB     = 3;
   localparam int          STRAP_LSB     = 1;
   localparam int          RW_POS        = 0;
   localparam int          STRAP_BITS    = 3;
   localparam logic [12:0] PTR_RST       = 13'h0000;
   localparam int          SYS_CLK_KHZ   = 20000;
   localparam int          SCL_MAX_KHZ   = 400;
   localparam int          SCL_QTR_CYCLES =
      (SYS_CLK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);

   typedef enum logic [2:0] {
      NVS_IDLE, NVS_DEV, NVS_ADDR_HI, NVS_ADDR_LO, NVS_WDATA, NVS_RDATA, NVS_IGNORE
   } nvs_dev_state_t;

   typedef enum logic [2:0] {
      NVS_H_IDLE, NVS_H_START, NVS_H_BIT, NVS_H_STOP, NVS_H_DONE
   } nvs_host_state_t;

endpackage : nvs_pkg

// ---- logic/nvs_bus_if.sv ----
// Two-wire bus carrier joining the master end and the memory end.
`timescale 1ns/1ps
interface nvs_bus_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic sda;

   // Wired level of the data line with its pull-up; any enabled low wins.
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

   modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
   modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface : nvs_bus_if

// ---- logic/nvs_device.sv ----
// Memory end: serial slave clocked by the bus clock, with its byte array.
`timescale 1ns/1ps
module nvs_device
(
   nvs_bus_if.slave    bus,
   input  wire logic   rst_b,
   input  wire logic   strap_select_bit0,
   input  wire logic   strap_select_bit1,
   input  wire logic   strap_select_bit2,
   input  wire logic   write_lock
);
   import nvs_pkg::*;

   localparam int PINS = STRAP_BITS + 1;

   nvs_dev_state_t          state;
   logic [BYTE_BITS-1:0]    mem [0:MEM_WORDS-1];
   logic [ADDR_W-1:0]       ptr;
   logic [3:0]              bit_cnt;
   logic [BYTE_BITS-2:0]    shreg;
   logic [BYTE_BITS-1:0]    tx_byte;
   logic [BYTE_BITS-1:0]    rx_byte;
   logic                    ack_en;
   logic                    drive_low;
   logic                    start_tgl;
   logic                    start_seen;
   logic                    stop_tgl;
   logic                    stop_seen;
   logic                    start_pend;
   logic                    stop_pend;
   logic                    byte_end;
   logic                    ack_slot;
   logic                    load_tx;
   logic [PINS-1:0]         pin_raw;
   logic [PINS-1:0]         pin_filt;
   logic [STRAP_BITS-1:0]   straps;
   logic                    lock;

   // Checks the type code and strap code of an address byte.
   function automatic logic addr_match
   (
      input logic [BYTE_BITS-1:0]  b,
      input logic [STRAP_BITS-1:0] s
   );
      addr_match = (b[TYPE_MSB:TYPE_LSB] == TYPE_CODE) &&
                   (b[STRAP_MSB:STRAP_LSB] == s);
   endfunction : addr_match

   // Pin levels; open pins are pulled low outside, so they read as zero.
   assign pin_raw = {write_lock, strap_select_bit2, strap_select_bit1,
                     strap_select_bit0};                               // [R3] [R8]

   // Each pin passes three flops; a change counts once the last two agree.
   generate
      for (genvar i = 0; i < PINS; i++)
      begin : g_pin
         logic [2:0] sync;
         always_ff @(posedge bus.scl or negedge rst_b)
         begin
            if (!rst_b)
            begin
               sync        <= 3'h0;
               pin_filt[i] <= 1'b0;
            end
            else
            begin
               sync <= {sync[1:0], pin_raw[i]};
               if (sync[1] == sync[2])
               begin
                  pin_filt[i] <= sync[2];
               end
            end
         end
      end
   endgenerate

   assign straps = pin_filt[STRAP_BITS-1:0];
   assign lock   = pin_filt[STRAP_BITS];

   // Start marker: data falls while the clock is high.
   always_ff @(negedge bus.sda or negedge rst_b)
   begin
      if (!rst_b)
      begin
         start_tgl <= 1'b0;
      end
      else if (bus.scl)
      begin
         start_tgl <= ~start_tgl;                                      // [R11]
      end
   end

   // Stop marker: data rises while the clock is high.
   always_ff @(posedge bus.sda or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stop_tgl <= 1'b0;
      end
      else if (bus.scl)
      begin
         stop_tgl <= ~stop_tgl;                                        // [R12]
      end
   end

   // A marker is pending until the next rising clock edge takes it over.
   assign start_pend = start_tgl ^ start_seen;
   assign stop_pend  = stop_tgl ^ stop_seen;
   assign rx_byte    = {shreg, bus.sda};
   assign byte_end   = (bit_cnt == LAST_BIT) && !start_pend;
   assign ack_slot   = (bit_cnt == ACK_BIT) && !start_pend && !stop_pend;

   // Records the markers seen at each rising clock edge.
   always_ff @(posedge bus.scl or negedge rst_b)
   begin
      if (!rst_b)
      begin
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
      end
      else
      begin
         start_seen <= start_tgl;
         stop_seen  <= stop_tgl;
      end
   end

   // Bit counter and receive shifter; data is sampled on the rising edge.
   always_ff @(posedge bus.scl or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bit_cnt <= 4'h0;
         shreg   <= 7'h00;
      end
      else
      begin
         shreg <= rx_byte[BYTE_BITS-2:0];                              // [R5]
         if (start_pend)
         begin
            bit_cnt <= 4'h1;
         end
         else if (bit_cnt == ACK_BIT)
         begin
            bit_cnt <= 4'h0;
         end
         else
         begin
            bit_cnt <= bit_cnt + 4'h1;
         end
      end
   end

   // Transfer state and acknowledge decision at the end of each byte.
   always_ff @(posedge bus.scl or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state  <= NVS_IDLE;
         ack_en <= 1'b0;
      end
      else if (start_pend)
      begin
         state  <= NVS_DEV;
         ack_en <= 1'b0;
      end
      else if (stop_pend)
      begin
         state  <= NVS_IDLE;                                           // [R12] [R16]
         ack_en <= 1'b0;
      end
      else if (byte_end)
      begin
         case (state)
            NVS_DEV:
            begin
               if (addr_match(rx_byte, straps))                        // [R2]
               begin
                  ack_en <= 1'b1;
                  state  <= rx_byte[RW_POS] ? NVS_RDATA : NVS_ADDR_HI; // [R20]
               end
               else
               begin
                  state <= NVS_IGNORE;                                 // [R19]
               end
            end
            NVS_ADDR_HI:
            begin
               ack_en <= 1'b1;
               state  <= NVS_ADDR_LO;                                  // [R21]
            end
            NVS_ADDR_LO:
            begin
               ack_en <= 1'b1;
               state  <= NVS_WDATA;
            end
            NVS_WDATA:
            begin
               ack_en <= 1'b1;
            end
            default:
            begin
               ack_en <= 1'b0;
            end
         endcase
      end
      else if (ack_slot)
      begin
         ack_en <= 1'b0;
         if ((state == NVS_RDATA) && !ack_en && bus.sda)
         begin
            state <= NVS_IGNORE;                                       // [R17]
         end
      end
   end

   // Next read byte is fetched on the first slot or on the master's low.
   assign load_tx = ack_slot && (state == NVS_RDATA) && (ack_en || !bus.sda);

   // Address pointer and read data; write-lock never gates this path.
   always_ff @(posedge bus.scl or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ptr     <= PTR_RST;
         tx_byte <= 8'h00;
      end
      else if (load_tx)
      begin
         tx_byte <= mem[ptr];                                          // [R7] [R23]
         ptr     <= ptr + 13'h0001;                                    // [R22]
      end
      else if (byte_end)
      begin
         case (state)
            NVS_ADDR_HI: ptr[ADDR_W-1:BYTE_BITS] <= rx_byte[ADDR_W-BYTE_BITS-1:0];
            NVS_ADDR_LO: ptr[BYTE_BITS-1:0] <= rx_byte;
            NVS_WDATA:   ptr <= ptr + 13'h0001;                        // [R22]
            default:     ptr <= ptr;
         endcase
      end
   end

   // Storage write; the byte lands as soon as it is complete.
   always_ff @(posedge bus.scl)
   begin
      if (byte_end && (state == NVS_WDATA) && !stop_pend && !lock)     // [R6]
      begin
         mem[ptr] <= rx_byte;                                          // [R1] [R13]
      end
   end

   // Output bits change on the falling edge, while the clock is low.
   always_ff @(negedge bus.scl or negedge rst_b)
   begin
      if (!rst_b)
      begin
         drive_low <= 1'b0;
      end
      else if (start_pend || stop_pend)
      begin
         drive_low <= 1'b0;
      end
      else if (bit_cnt == ACK_BIT)
      begin
         drive_low <= ack_en;                                          // [R14] [R15]
      end
      else if (state == NVS_RDATA)
      begin
         drive_low <= ~tx_byte[3'(4'h7 - bit_cnt)];                    // [R5] [R10]
      end
      else
      begin
         drive_low <= 1'b0;                                            // [R17] [R19]
      end
   end

   // Open-drain pin: output fixed low, only the enable moves.
   assign bus.s_sda_o  = 1'b0;                                         // [R4]
   assign bus.s_sda_oe = drive_low && !stop_pend && !start_pend;       // [R4] [R13]

endmodule : nvs_device

// ---- logic/nvs_host.sv ----
// Master end: byte-level two-wire bus master with a clock divider.
`timescale 1ns/1ps
module nvs_host
#(
   parameter int QTR_CYCLES = nvs_pkg::SCL_QTR_CYCLES
)
(
   nvs_bus_if.master   bus,
   input  wire logic   sys_clk,
   input  wire logic   rst_b,
   input  wire logic   cmd_valid,
   output logic        cmd_ready,
   input  wire logic   cmd_start,
   input  wire logic   cmd_stop,
   input  wire logic   cmd_read,
   input  wire logic   cmd_nack,
   input  wire logic [7:0] cmd_wdata,
   output logic        rsp_valid,
   output logic [7:0]  rsp_data,
   output logic        rsp_ack
);
   import nvs_pkg::*;

   localparam int QW = $clog2(QTR_CYCLES + 1);

   nvs_host_state_t  state;
   logic [QW-1:0]    qcnt;
   logic             tick;
   logic [1:0]       phase;
   logic [3:0]       bitn;
   logic [7:0]       tx;
   logic             rd;
   logic             nack;
   logic             stop_after;
   logic             scl_o;
   logic             m_oe;
   logic [2:0]       sync;
   logic             sda_f;

   // Data line input passes three flops; it changes once the last two agree.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync  <= 3'h7;
         sda_f <= 1'b1;
      end
      else
      begin
         sync <= {sync[1:0], bus.sda};
         if (sync[1] == sync[2])
         begin
            sda_f <= sync[2];
         end
      end
   end

   // Quarter-period divider of the bus clock, running only during commands.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         qcnt <= '0;
      end
      else if ((state == NVS_H_IDLE) || tick)
      begin
         qcnt <= '0;
      end
      else
      begin
         qcnt <= qcnt + QW'(1);                                        // [R18]
      end
   end

   assign tick      = (qcnt == QW'(QTR_CYCLES - 1));
   assign cmd_ready = (state == NVS_H_IDLE);

   // Sequencer: optional start, nine bit slots, optional stop, then one response.
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state      <= NVS_H_IDLE;
         phase      <= 2'h0;
         bitn       <= 4'h0;
         tx         <= 8'h00;
         rd         <= 1'b0;
         nack       <= 1'b0;
         stop_after <= 1'b0;
         scl_o      <= 1'b1;
         m_oe       <= 1'b0;
         rsp_valid  <= 1'b0;
         rsp_data   <= 8'h00;
         rsp_ack    <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         case (state)
            NVS_H_IDLE:
            begin
               if (cmd_valid)                                          // [R9]
               begin
                  tx         <= cmd_wdata;
                  rd         <= cmd_read;
                  nack       <= cmd_nack;
                  stop_after <= cmd_stop;
                  phase      <= 2'h0;
                  bitn       <= 4'h0;
                  state      <= cmd_start ? NVS_H_START : NVS_H_BIT;
               end
            end
            NVS_H_START:
            begin
               if (tick)
               begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: scl_o <= 1'b0;
                     2'h1: scl_o <= 1'b1;
                     2'h2: m_oe  <= 1'b1;                              // [R11]
                     default:
                     begin
                        scl_o <= 1'b0;
                        state <= NVS_H_BIT;
                     end
                  endcase
                  if (phase == 2'h0)
                  begin
                     m_oe <= 1'b0;
                  end
               end
            end
            NVS_H_BIT:
            begin
               if (tick)
               begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0:
                     begin
                        if (bitn == ACK_BIT)
                        begin
                           m_oe <= rd && !nack;                        // [R14] [R15]
                        end
                        else
                        begin
                           m_oe <= !rd && !tx[3'(4'h7 - bitn)];        // [R10]
                        end
                     end
                     2'h1: scl_o <= 1'b1;
                     2'h2:
                     begin
                        if (bitn == ACK_BIT)
                        begin
                           rsp_ack <= !sda_f;
                        end
                        else
                        begin
                           rsp_data <= {rsp_data[6:0], sda_f};
                        end
                     end
                     default:
                     begin
                        scl_o <= 1'b0;
                        bitn  <= bitn + 4'h1;
                        if (bitn == ACK_BIT)
                        begin
                           state <= stop_after ? NVS_H_STOP : NVS_H_DONE;
                        end
                     end
                  endcase
               end
            end
            NVS_H_STOP:
            begin
               if (tick)
               begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: m_oe  <= 1'b1;
                     2'h1: scl_o <= 1'b1;
                     2'h2: m_oe  <= 1'b0;                              // [R12]
                     default: state <= NVS_H_DONE;
                  endcase
               end
            end
            NVS_H_DONE:
            begin
               rsp_valid <= 1'b1;
               state     <= NVS_H_IDLE;
            end
            default:
            begin
               state <= NVS_H_IDLE;
            end
         endcase
      end
   end

   // Clock is push-pull; data is open-drain with a fixed low output.
   assign bus.scl      = scl_o;                                        // [R9]
   assign bus.m_sda_o  = 1'b0;
   assign bus.m_sda_oe = m_oe;

endmodule : nvs_host

// ---- verif/nvs_bus_sva.sv ----
// Bus-level assertions watching both ends of the two-wire memory link.
`timescale 1ns/1ps
module nvs_bus_sva
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic [2:0] strap_set,
   input  wire logic       scl,
   input  wire logic       m_sda_o,
   input  wire logic       m_sda_oe,
   input  wire logic       s_sda_o,
   input  wire logic       s_sda_oe,
   input  wire logic       sda
);
   import nvs_pkg::*;
   logic [3:0] bit_cnt;
   logic [3:0] byte_idx;
   logic [7:0] shift;
   logic [7:0] per_cnt;
   logic       rw;
   logic       mute;
   logic       idle;
   logic       addr_miss;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // The address byte is compared with the type code and the straps.
   assign addr_miss = shift[7:1] != {TYPE_CODE, strap_set};

   // Cycles since the last rise of the bus clock; saturates so reset never trips.
   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b) per_cnt <= 8'hFF;
      else if ($rose(scl)) per_cnt <= 8'h00;
      else if (per_cnt != 8'hFF) per_cnt <= per_cnt + 8'h01;

   // Frame tracker: bit and byte counts, direction and the silence flags.
   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
      begin
         bit_cnt  <= 4'h0;
         byte_idx <= 4'h0;
         shift    <= 8'h00;
         rw       <= 1'b0;
         mute     <= 1'b0;
         idle     <= 1'b1;
      end
      else if ($fell(sda) && scl && $past(scl))
      begin
         bit_cnt  <= 4'h0;
         byte_idx <= 4'h0;
         mute     <= 1'b0;
         idle     <= 1'b0;
      end
      else if ($rose(sda) && scl && $past(scl))
      begin
         mute <= 1'b0;
         idle <= 1'b1;
      end
      else if ($rose(scl) && bit_cnt == 4'h8)
      begin
         bit_cnt  <= 4'h0;
         byte_idx <= (byte_idx == 4'hF) ? byte_idx : byte_idx + 4'h1;
         if (byte_idx == 4'h0) rw <= shift[0];
         if (byte_idx == 4'h0 ? addr_miss : (rw && sda)) mute <= 1'b1;
      end
      else if ($rose(scl))
      begin
         bit_cnt <= bit_cnt + 4'h1;
         shift   <= {shift[6:0], sda};
      end

   // The acknowledge slot of each byte.
   sequence s_ninth_rise;
      $rose(scl) && bit_cnt == 4'h8;
   endsequence

   a_open_drain: assert property ((s_sda_oe |-> !s_sda_o) and (m_sda_oe |-> !m_sda_o))
      else $error("data line driven high");
   a_rise_when_low: assert property ($rose(s_sda_oe) |-> !scl)
      else $error("device pulled data low while clock high");
   a_hold_while_high: assert property ($rose(scl) && s_sda_oe |-> s_sda_oe [*8])
      else $error("device changed data while clock high");
   a_one_driver: assert property ($rose(scl) |-> !(m_sda_oe && s_sda_oe))
      else $error("both ends drive data at a clock rise");
   a_scl_rate: assert property ($rose(scl) |-> per_cnt >= 8'h31)
      else $error("bus clock period under fifty cycles");
   a_addr_ack: assert property (s_ninth_rise ##0
         (byte_idx == 4'h0 ? !addr_miss : (!rw && !mute)) |-> s_sda_oe)
      else $error("device missed an acknowledge");
   a_nomatch_quiet: assert property (s_ninth_rise ##0
         (byte_idx == 4'h0 && addr_miss) |-> !s_sda_oe)
      else $error("device acknowledged a foreign address");
   a_muted_release: assert property (mute |-> !s_sda_oe)
      else $error("device drove data after no acknowledge");
   a_idle_quiet: assert property (idle |-> !s_sda_oe)
      else $error("device drove data after stop");
   a_start_by_host: assert property ($fell(sda) && scl && $past(scl) |-> m_sda_oe)
      else $error("start formed without the host driving data");
endmodule : nvs_bus_sva

// ---- verif/testbench.sv ----
// Self-checking bench: the host end talks to the memory end over the bus.
`timescale 1ns/1ps
module testbench;
   import nvs_pkg::*;
   localparam int         LIMIT = 80000;
   localparam logic [3:0] F_S   = 4'h8;
   localparam logic [3:0] F_P   = 4'h4;
   localparam logic [3:0] F_R   = 4'h2;
   localparam logic [3:0] F_N   = 4'h1;
   logic        sys_clk;
   logic        rst_b;
   logic [2:0]  strap;
   logic        write_lock;
   logic        cmd_valid;
   logic        cmd_ready;
   logic        cmd_start;
   logic        cmd_stop;
   logic        cmd_read;
   logic        cmd_nack;
   logic [7:0]  cmd_wdata;
   logic        rsp_valid;
   logic [7:0]  rsp_data;
   logic        rsp_ack;
   logic [12:0] ptr;
   logic [7:0]  model [MEM_WORDS];
   int          error_cnt;
   int          comparisons;
   int          cycles;

   nvs_bus_if bus_if ();
   nvs_host u_nvs_host (.bus(bus_if), .sys_clk, .rst_b, .cmd_valid, .cmd_ready, .cmd_start,
      .cmd_stop, .cmd_read, .cmd_nack, .cmd_wdata, .rsp_valid, .rsp_data, .rsp_ack);
   nvs_device u_nvs_device (.bus(bus_if), .rst_b, .strap_select_bit0(strap[0]),
      .strap_select_bit1(strap[1]), .strap_select_bit2(strap[2]), .write_lock);
   nvs_bus_sva u_nvs_bus_sva (.sys_clk, .rst_b, .strap_set(strap), .scl(bus_if.scl),
      .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe), .s_sda_o(bus_if.s_sda_o),
      .s_sda_oe(bus_if.s_sda_oe), .sda(bus_if.sda));

   // System clock of 50 ns.
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run

   // Cuts a hung run short.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One byte command; waits for the one-cycle response under a bound.
   task automatic xfer(input logic [3:0] f, input logic [7:0] d);
      int k;
      k = 0;
      @(negedge sys_clk);
      check(8'(cmd_ready), 8'h01);
      {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack, cmd_wdata} = {1'b1, f, d};
      @(posedge sys_clk);
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      check(8'(cmd_ready), 8'h00);
      while (rsp_valid !== 1'b1 && k < 3000)
      begin
         @(negedge sys_clk);
         k++;
      end
      check(8'(k == 3000), 8'h00);
      if (f[1] == 1'b0) check(rsp_data, d);
      else check(8'(rsp_ack), 8'(!f[0]));
   endtask : xfer

   // Addresses the device for writing and loads the pointer.
   task automatic set_ptr(input logic [12:0] a);
      xfer(F_S, {TYPE_CODE, strap, 1'b0});
      check(8'(rsp_ack), 8'h01);
      xfer(4'h0, {3'h0, a[12:8]});
      check(8'(rsp_ack), 8'h01);
      xfer(4'h0, a[7:0]);
      check(8'(rsp_ack), 8'h01);
   endtask : set_ptr

   task automatic write_run(input logic [12:0] a, input logic [7:0] d, input int n);
      set_ptr(a);
      for (int i = 0; i < n; i++)
      begin
         xfer((i == n - 1) ? F_P : 4'h0, d + 8'(i));
         check(8'(rsp_ack), 8'h01);
         if (write_lock == 1'b0) model[a + 13'(i)] = d + 8'(i);
      end
      ptr = a + 13'(n);
   endtask : write_run

   // Reads n bytes from a, or from the current pointer when cur is set.
   task automatic read_run(input logic [12:0] a, input int n, input logic stp, input logic cur);
      if (!cur) set_ptr(a);
      xfer(F_S, {TYPE_CODE, strap, 1'b1});
      check(8'(rsp_ack), 8'h01);
      for (int i = 0; i < n; i++)
      begin
         xfer((i == n - 1) ? (F_R | F_N | (stp ? F_P : 4'h0)) : F_R, 8'h00);
         check(rsp_data, model[a + 13'(i)]);
      end
      ptr = a + 13'(n);
   endtask : read_run

   // Main sequence.
   initial
   begin
      {rst_b, write_lock, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack} = 7'h00;
      strap = 3'h5;
      cmd_wdata = 8'h00;
      error_cnt = 0;
      comparisons = 0;
      cycles = 0;
      repeat (20) @(negedge sys_clk);
      rst_b = 1'b1;
      write_run(13'h0100, 8'h3C, 4);
      read_run(13'h0100, 4, 1'b1, 1'b0);
      $display("burst test done");
      write_run(13'h1FFE, 8'hA0, 4);
      read_run(13'h1FFE, 3, 1'b1, 1'b0);
      read_run(ptr, 1, 1'b0, 1'b1);
      $display("wrap and current address test done");
      write_lock = 1'b1;
      write_run(13'h0100, 8'h77, 2);
      read_run(13'h0100, 2, 1'b1, 1'b0);
      write_lock = 1'b0;
      $display("write lock test done");
      for (int c = 0; c < 8; c++)
      begin
         xfer(F_S | F_P, {TYPE_CODE, 3'(c), 1'b0});
         check(8'(rsp_ack), 8'(3'(c) == strap));
      end
      // A foreign type code, then one more byte that must stay unanswered.
      xfer(F_S, {TYPE_CODE ^ 4'h1, strap, 1'b0});
      check(8'(rsp_ack), 8'h00);
      xfer(F_P, 8'h00);
      check(8'(rsp_ack), 8'h00);
      strap = 3'h0;
      read_run(13'h0100, 1, 1'b1, 1'b0);
      $display("address match test done");
      complete_run();
   end
endmodule : testbench
